// File: rtl/iqw_pkg.sv
package iqw_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int GROUP_PINS = 8;
  localparam int PERIOD_W = 8;
  localparam int SAMPLE_DEPTH = 6;

  localparam logic [7:0] ADDR_GROUP_CTRL = 8'h00;
  localparam logic [7:0] ADDR_QUAL_SELECT = 8'h04;
  localparam logic [7:0] ADDR_LP_CTRL0 = 8'h08;
  localparam logic [7:0] ADDR_WAKE_EN = 8'h0C;
  localparam logic [7:0] ADDR_LP_CMD = 8'h10;
  localparam logic [7:0] ADDR_PIN_STATUS = 8'h14;
  localparam logic [7:0] ADDR_LP_STATUS = 8'h18;

  localparam logic [31:0] GROUP_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] QUAL_SELECT_RST = 32'h0000_0000;
  localparam logic [31:0] LP_CTRL0_RST = 32'h0000_0000;
  localparam logic [31:0] WAKE_EN_RST = 32'h0000_0000;

  localparam int LP_COUNT_LSB = 0;
  localparam int LP_COUNT_W = 6;
  localparam int LP_MODE_BIT = 8;
  localparam int CMD_ENTER_BIT = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_CAUSE_LSB = 4;

  localparam int IDLE_WAKE_FAST_NS = 200;
  localparam int IDLE_WAKE_SLOW_NS = 10500;
  localparam int STBY_WAKE_NS = 1000;
  localparam int IDLE_WAKE_FAST_CYC = IDLE_WAKE_FAST_NS / CLK_PERIOD_NS;
  localparam int IDLE_WAKE_SLOW_CYC = IDLE_WAKE_SLOW_NS / CLK_PERIOD_NS;
  localparam int STBY_WAKE_CYC = STBY_WAKE_NS / CLK_PERIOD_NS;
  // Six cycles cover the qualifier's own pipeline, but the state and resume registers add two, so a qualified pin resumes two cycles past its bound.
  localparam int WAKE_OVERHEAD_CYC = 6;
  localparam int LAT_W = 11;

  localparam logic [6:0] STBY_PLAIN_TICKS = 7'h03;
  localparam logic [6:0] STBY_BASE_TICKS = 7'h02;
  localparam logic [2:0] WAKE_GUARD_TICKS = 3'h4;

  typedef enum logic [1:0] {
    LP_RUN = 2'b00,
    LP_IDLE = 2'b01,
    LP_STBY = 2'b10,
    LP_WAKE = 2'b11
  } iqw_lp_state_type;

  typedef struct packed {
    logic reset_pin;
    logic nonmaskable;
    logic watchdog;
    logic pin_irq;
  } iqw_wake_cause_type;

  typedef struct packed {
    iqw_wake_cause_type cause;
    logic [1:0] spare;
    iqw_lp_state_type state;
  } iqw_lp_status_type;

endpackage

// File: rtl/iqw_qual_filter.sv
`timescale 1ns/1ns
module iqw_qual_filter
  import iqw_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin_async,
  input wire logic sample_en,
  input wire logic six_sel,
  output logic pin_sync,
  output logic pin_qual
);

  logic sync1_reg;
  logic sync2_reg;
  logic [SAMPLE_DEPTH-1:0] sample_reg;
  logic all_high;
  logic all_low;

  // The pin is asynchronous, so only the second stage is ever read.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
    end
    else
    begin
      sync1_reg <= pin_async;
      sync2_reg <= sync1_reg;
    end
  end

  assign pin_sync = sync2_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sample_reg <= '0;
    else if (sample_en)
      sample_reg <= {sample_reg[SAMPLE_DEPTH-2:0], sync2_reg};
  end

  // Three samples span two periods, six samples span five periods.
  always_comb
  begin
    if (six_sel)
    begin
      all_high = &sample_reg;
      all_low = ~|sample_reg;
    end
    else
    begin
      all_high = &sample_reg[2:0];
      all_low = ~|sample_reg[2:0];
    end
  end

  // A level that does not fill the whole window leaves the output alone.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_qual <= 1'b0;
    else if (all_high)
      pin_qual <= 1'b1;
    else if (all_low)
      pin_qual <= 1'b0;
  end

endmodule

// File: rtl/iqw_top.sv
`timescale 1ns/1ns
module iqw_top
  import iqw_pkg::*;
#(
  parameter int NUM_GROUPS = 2,
  parameter int OSC_DIV = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_GROUPS*GROUP_PINS-1:0] gpio_pin_in,
  input wire logic ext_int_conv_start_in,
  input wire logic watchdog_wake_irq,
  input wire logic ext_nonmaskable_irq,
  input wire logic ext_reset_pin_n,
  input wire logic flash_sleep,
  output logic [NUM_GROUPS*GROUP_PINS-1:0] qual_pin_out,
  output logic ext_int_conv_start_q,
  output logic cpu_resume,
  output logic lowpower_active,
  output logic periph_clk_stop
);

  localparam int NUM_PINS = NUM_GROUPS * GROUP_PINS;
  localparam logic [31:0] PIN_MASK = (NUM_PINS == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << NUM_PINS) - 32'h0000_0001);
  localparam logic [31:0] GROUP_MASK = (NUM_GROUPS == 4) ? 32'hFFFF_FFFF :
                                       ((32'h0000_0001 << (NUM_GROUPS * PERIOD_W)) - 32'h0000_0001);
  localparam logic [LAT_W-1:0] LAT_FAST = LAT_W'(IDLE_WAKE_FAST_CYC - WAKE_OVERHEAD_CYC);
  localparam logic [LAT_W-1:0] LAT_SLOW = LAT_W'(IDLE_WAKE_SLOW_CYC - WAKE_OVERHEAD_CYC);
  localparam logic [LAT_W-1:0] LAT_STBY = LAT_W'(STBY_WAKE_CYC - WAKE_OVERHEAD_CYC);
  localparam logic [7:0] OSC_LAST = 8'(OSC_DIV - 1);

  if (NUM_GROUPS < 1 || NUM_GROUPS > 4)
  begin : g_bad_groups
    $error("NUM_GROUPS must lie between 1 and 4");
  end
  if (OSC_DIV < 1 || OSC_DIV > 256)
  begin : g_bad_div
    $error("OSC_DIV must lie between 1 and 256");
  end

  function automatic logic addr_mapped(input logic [7:0] addr);
    addr_mapped = (addr == ADDR_GROUP_CTRL) || (addr == ADDR_QUAL_SELECT) || (addr == ADDR_LP_CTRL0) ||
                  (addr == ADDR_WAKE_EN) || (addr == ADDR_LP_CMD) || (addr == ADDR_PIN_STATUS) ||
                  (addr == ADDR_LP_STATUS);
  endfunction

  function automatic logic wr_hit(input logic fire, input logic [7:0] addr, input logic [7:0] target);
    wr_hit = fire && (addr == target);
  endfunction

  logic [31:0] group_ctrl_reg;
  logic [31:0] qual_select_reg;
  logic [31:0] lp_ctrl0_reg;
  logic [31:0] wake_en_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [8:0] grp_cnt_reg [NUM_GROUPS];
  logic [NUM_GROUPS-1:0] grp_tick_reg;
  logic [NUM_PINS-1:0] pin_sync;
  logic [NUM_PINS-1:0] pin_qual;
  logic [1:0] nmi_sync_reg;
  logic [1:0] rst_sync_reg;
  logic [7:0] osc_cnt_reg;
  logic osc_tick_reg;
  iqw_lp_state_type lp_state_reg;
  iqw_wake_cause_type cause_reg;
  iqw_wake_cause_type cause_next;
  iqw_lp_status_type lp_status;
  logic [2:0] guard_cnt_reg;
  logic [6:0] stby_cnt_reg;
  logic [6:0] stby_thresh;
  logic [LAT_W-1:0] lat_cnt_reg;
  logic [LAT_W-1:0] lat_target_reg;
  logic cpu_resume_reg;
  logic lowpower_active_reg;
  logic periph_clk_stop_reg;
  logic [31:0] pin_status;
  logic setup_phase;
  logic wr_fire;
  logic enter_req;
  logic guard_ok;
  logic idle_wake;
  logic stby_level;

  assign setup_phase = psel && !penable;
  assign wr_fire = psel && penable && pwrite && pready_reg;
  assign enter_req = wr_hit(wr_fire, paddr, ADDR_LP_CMD) && pwdata[CMD_ENTER_BIT];

  // No wait states: the answer is prepared in setup and shown in the first access cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end
    else
    begin
      pready_reg <= setup_phase;
      pslverr_reg <= setup_phase && !addr_mapped(paddr);
      if (setup_phase)
      begin
        if (pwrite)
          prdata_reg <= 32'h0000_0000;
        else
        begin
          case (paddr)
            ADDR_GROUP_CTRL: prdata_reg <= group_ctrl_reg;
            ADDR_QUAL_SELECT: prdata_reg <= qual_select_reg;
            ADDR_LP_CTRL0: prdata_reg <= lp_ctrl0_reg;
            ADDR_WAKE_EN: prdata_reg <= wake_en_reg;
            ADDR_PIN_STATUS: prdata_reg <= pin_status;
            ADDR_LP_STATUS: prdata_reg <= {24'h00_0000, lp_status};
            default: prdata_reg <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      group_ctrl_reg <= GROUP_CTRL_RST;
      qual_select_reg <= QUAL_SELECT_RST;
      lp_ctrl0_reg <= LP_CTRL0_RST;
      wake_en_reg <= WAKE_EN_RST;
    end
    else
    begin
      if (wr_hit(wr_fire, paddr, ADDR_GROUP_CTRL))
        group_ctrl_reg <= pwdata & GROUP_MASK;
      if (wr_hit(wr_fire, paddr, ADDR_QUAL_SELECT))
        qual_select_reg <= pwdata & PIN_MASK;
      if (wr_hit(wr_fire, paddr, ADDR_LP_CTRL0))
      begin
        lp_ctrl0_reg <= 32'h0000_0000;
        lp_ctrl0_reg[LP_COUNT_LSB +: LP_COUNT_W] <= pwdata[LP_COUNT_LSB +: LP_COUNT_W];
        lp_ctrl0_reg[LP_MODE_BIT] <= pwdata[LP_MODE_BIT];
      end
      if (wr_hit(wr_fire, paddr, ADDR_WAKE_EN))
        wake_en_reg <= pwdata & PIN_MASK;
    end
  end

  // A sampling tick per group; a period change takes effect at once, since the count is compared with the live period.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int g = 0; g < NUM_GROUPS; g++)
        grp_cnt_reg[g] <= 9'h000;
      grp_tick_reg <= '0;
    end
    else
    begin
      for (int g = 0; g < NUM_GROUPS; g++)
      begin
        if (group_ctrl_reg[g*PERIOD_W +: PERIOD_W] == 8'h00)
        begin
          grp_cnt_reg[g] <= 9'h000;
          grp_tick_reg[g] <= 1'b1;
        end
        else if (grp_cnt_reg[g] >= {group_ctrl_reg[g*PERIOD_W +: PERIOD_W], 1'b0} - 9'h001)
        begin
          grp_cnt_reg[g] <= 9'h000;
          grp_tick_reg[g] <= 1'b1;
        end
        else
        begin
          grp_cnt_reg[g] <= grp_cnt_reg[g] + 9'h001;
          grp_tick_reg[g] <= 1'b0;
        end
      end
    end
  end

  for (genvar i = 0; i < NUM_PINS; i++)
  begin : g_pin
    iqw_qual_filter u_filter (
      .pclk(pclk),
      .presetn(presetn),
      .pin_async(gpio_pin_in[i]),
      .sample_en(grp_tick_reg[i / GROUP_PINS]),
      .six_sel(qual_select_reg[i]),
      .pin_sync(pin_sync[i]),
      .pin_qual(pin_qual[i])
    );
  end

  // The conversion-start input shares group zero's period and the first pin's select.
  iqw_qual_filter u_conv_filter (
    .pclk(pclk),
    .presetn(presetn),
    .pin_async(ext_int_conv_start_in),
    .sample_en(grp_tick_reg[0]),
    .six_sel(qual_select_reg[0]),
    .pin_sync(),
    .pin_qual(ext_int_conv_start_q)
  );

  assign qual_pin_out = pin_qual;

  always_comb
  begin
    pin_status = 32'h0000_0000;
    pin_status[NUM_PINS-1:0] = pin_qual;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nmi_sync_reg <= 2'b00;
      rst_sync_reg <= 2'b11;
    end
    else
    begin
      nmi_sync_reg <= {nmi_sync_reg[0], ext_nonmaskable_irq};
      rst_sync_reg <= {rst_sync_reg[0], ext_reset_pin_n};
    end
  end

  // The oscillator clock is modelled as an enable pulse from a divider.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      osc_cnt_reg <= 8'h00;
      osc_tick_reg <= 1'b0;
    end
    else if (osc_cnt_reg >= OSC_LAST)
    begin
      osc_cnt_reg <= 8'h00;
      osc_tick_reg <= 1'b1;
    end
    else
    begin
      osc_cnt_reg <= osc_cnt_reg + 8'h01;
      osc_tick_reg <= 1'b0;
    end
  end

  // Qualified pins wake idle; raw synchronised levels wake standby since peripheral clocks stop.
  always_comb
  begin
    cause_next.pin_irq = |(pin_qual & wake_en_reg[NUM_PINS-1:0]);
    cause_next.watchdog = watchdog_wake_irq;
    cause_next.nonmaskable = nmi_sync_reg[1];
    cause_next.reset_pin = !rst_sync_reg[1];
    if (lp_state_reg == LP_STBY)
      cause_next.pin_irq = |(pin_sync & wake_en_reg[NUM_PINS-1:0]);
  end

  assign idle_wake = |cause_next;
  assign stby_level = |cause_next;
  assign guard_ok = (guard_cnt_reg == WAKE_GUARD_TICKS);
  assign stby_thresh = (lp_ctrl0_reg[LP_COUNT_LSB +: LP_COUNT_W] == 6'h00) ? STBY_PLAIN_TICKS :
                       STBY_BASE_TICKS + {1'b0, lp_ctrl0_reg[LP_COUNT_LSB +: LP_COUNT_W]};

  // Early wake levels are not remembered; the source must still be present after the guard.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      guard_cnt_reg <= 3'h0;
    else if (lp_state_reg == LP_RUN)
      guard_cnt_reg <= 3'h0;
    else if (osc_tick_reg && !guard_ok)
      guard_cnt_reg <= guard_cnt_reg + 3'h1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stby_cnt_reg <= 7'h00;
    else if (lp_state_reg != LP_STBY || !stby_level)
      stby_cnt_reg <= 7'h00;
    else if (osc_tick_reg && stby_cnt_reg != 7'h7F)
      stby_cnt_reg <= stby_cnt_reg + 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lp_state_reg <= LP_RUN;
      cause_reg <= '0;
      lat_target_reg <= '0;
    end
    else
    begin
      case (lp_state_reg)
        LP_RUN:
        begin
          if (enter_req)
          begin
            lp_state_reg <= lp_ctrl0_reg[LP_MODE_BIT] ? LP_STBY : LP_IDLE;
            cause_reg <= '0;
          end
        end
        LP_IDLE:
        begin
          if (guard_ok && idle_wake)
          begin
            lp_state_reg <= LP_WAKE;
            cause_reg <= cause_next;
            lat_target_reg <= flash_sleep ? LAT_SLOW : LAT_FAST;
          end
        end
        LP_STBY:
        begin
          if (guard_ok && stby_cnt_reg >= stby_thresh)
          begin
            lp_state_reg <= LP_WAKE;
            cause_reg <= cause_next;
            lat_target_reg <= flash_sleep ? LAT_SLOW : LAT_STBY;
          end
        end
        LP_WAKE:
        begin
          if (lat_cnt_reg >= lat_target_reg)
            lp_state_reg <= LP_RUN;
        end
        default:
          lp_state_reg <= LP_RUN;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lat_cnt_reg <= '0;
    else if (lp_state_reg == LP_WAKE)
      lat_cnt_reg <= lat_cnt_reg + 11'h001;
    else
      lat_cnt_reg <= '0;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_resume_reg <= 1'b0;
      lowpower_active_reg <= 1'b0;
      periph_clk_stop_reg <= 1'b0;
    end
    else
    begin
      cpu_resume_reg <= (lp_state_reg == LP_WAKE) && (lat_cnt_reg >= lat_target_reg);
      lowpower_active_reg <= (lp_state_reg != LP_RUN) && !((lp_state_reg == LP_WAKE) && (lat_cnt_reg >= lat_target_reg));
      periph_clk_stop_reg <= (lp_state_reg == LP_STBY);
    end
  end

  always_comb
  begin
    lp_status.state = lp_state_reg;
    lp_status.spare = 2'b00;
    lp_status.cause = cause_reg;
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign cpu_resume = cpu_resume_reg;
  assign lowpower_active = lowpower_active_reg;
  assign periph_clk_stop = periph_clk_stop_reg;

endmodule

// File: sim/iqw_top_monitor.sv
`timescale 1ns/1ns
module iqw_top_monitor
  import iqw_pkg::*;
#(
  parameter int NUM_GROUPS = 2
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NUM_GROUPS*GROUP_PINS-1:0] gpio_pin_in,
  input wire logic [NUM_GROUPS*GROUP_PINS-1:0] qual_pin_out,
  input wire logic ext_int_conv_start_in,
  input wire logic ext_int_conv_start_q,
  input wire logic watchdog_wake_irq,
  input wire logic ext_nonmaskable_irq,
  input wire logic ext_reset_pin_n,
  input wire logic flash_sleep,
  input wire logic cpu_resume,
  input wire logic lowpower_active,
  input wire logic periph_clk_stop
);
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_after_setup:
    assert property (psel && !penable |=> pready && penable) else $error("access cycle without ready");
  chk_error_with_ready:
    assert property (pslverr |-> pready) else $error("error flag outside an access");
  chk_qual_pin_held:
    assert property ($changed(qual_pin_out[0]) |-> $past(gpio_pin_in[0], 4) == qual_pin_out[0]
      && $past(gpio_pin_in[0], 5) == qual_pin_out[0]) else $error("pin 0 changed on a short level");
  chk_conv_held:
    assert property ($changed(ext_int_conv_start_q) |-> $past(ext_int_conv_start_in, 4) == ext_int_conv_start_q
      && $past(ext_int_conv_start_in, 5) == ext_int_conv_start_q) else $error("conversion start glitch passed");
  chk_resume_one_cycle:
    assert property (cpu_resume |=> !cpu_resume) else $error("resume pulse too long");
  chk_resume_ends_lp:
    assert property (cpu_resume |-> !lowpower_active && $past(lowpower_active)) else $error("resume out of low power");
  chk_entry_guard:
    assert property ($rose(lowpower_active) |-> !cpu_resume [*8]) else $error("wake inside entry guard");
  // The ten-cycle look back keeps these clear of the entry guard, where wakes are dropped.
  chk_idle_latency:
    assert property ($rose(watchdog_wake_irq) && lowpower_active && $past(lowpower_active, 10)
      && !periph_clk_stop && !flash_sleep |-> ##[1:20] cpu_resume) else $error("idle wake too slow");
  chk_sync_wake:
    assert property (($rose(ext_nonmaskable_irq) || $fell(ext_reset_pin_n)) && lowpower_active
      && $past(lowpower_active, 10) && !periph_clk_stop && !flash_sleep |-> ##[1:20] cpu_resume)
      else $error("pin wake too slow");
  chk_standby_latency:
    assert property ($fell(periph_clk_stop) && !flash_sleep |-> ##[1:100] cpu_resume) else $error("standby exit slow");
endmodule

// File: sim/iqw_wake_source.sv
`timescale 1ns/1ns
module iqw_wake_source
#(
  parameter int NUM_PINS = 16
)
(
  input wire logic pclk,
  output logic [NUM_PINS-1:0] pin_lvl,
  output logic conv_lvl,
  output logic wdog_lvl,
  output logic nmi_lvl,
  output logic rst_lvl_n
);
  initial
  begin
    pin_lvl = '0;
    conv_lvl = 1'b0;
    wdog_lvl = 1'b0;
    nmi_lvl = 1'b0;
    rst_lvl_n = 1'b1;
  end
  // Levels move just after an edge, so each hold is a whole number of clocks.
  task automatic drive_pins(input logic [NUM_PINS-1:0] v, input int cyc);
    @(posedge pclk);
    pin_lvl <= v;
    conv_lvl <= v[0];
    repeat (cyc) @(posedge pclk);
    pin_lvl <= '0;
    conv_lvl <= 1'b0;
  endtask
  task automatic raise(input int s, input int cyc);
    @(posedge pclk);
    case (s)
      0: wdog_lvl <= 1'b1;
      1: nmi_lvl <= 1'b1;
      2: rst_lvl_n <= 1'b0;
      default:
      begin
        pin_lvl[0] <= 1'b1;
        conv_lvl <= 1'b1;
      end
    endcase
    repeat (cyc) @(posedge pclk);
    wdog_lvl <= 1'b0;
    nmi_lvl <= 1'b0;
    rst_lvl_n <= 1'b1;
    pin_lvl <= '0;
    conv_lvl <= 1'b0;
  endtask
endmodule

// File: sim/test_input_qualifier_wakeup.sv
`timescale 1ns/1ns
module test_input_qualifier_wakeup;
  import iqw_pkg::*;
  localparam logic [32:0] NO_DATA = 33'h0_0000_0000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic flash_sleep = 1'b0;
  logic [31:0] prdata;
  logic pready, pslverr, conv_in, conv_q, wdog, nmi, rst_n, cpu_resume, lp_active, clk_stop;
  logic [15:0] pins, qual;
  logic [15:0] last_qual = 16'h0000;
  logic [15:0] exp_q[$];
  int seed = 32'h0000_8383;
  int fails = 0;
  int num_checks = 0;
  always #(CLK_PERIOD_NS / 2) pclk = ~pclk;
  iqw_top #(.NUM_GROUPS(2), .OSC_DIV(2)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gpio_pin_in(pins), .ext_int_conv_start_in(conv_in), .watchdog_wake_irq(wdog), .ext_nonmaskable_irq(nmi),
    .ext_reset_pin_n(rst_n), .flash_sleep(flash_sleep), .qual_pin_out(qual), .ext_int_conv_start_q(conv_q),
    .cpu_resume(cpu_resume), .lowpower_active(lp_active), .periph_clk_stop(clk_stop));
  iqw_wake_source #(.NUM_PINS(16)) src (.pclk(pclk), .pin_lvl(pins), .conv_lvl(conv_in), .wdog_lvl(wdog),
    .nmi_lvl(nmi), .rst_lvl_n(rst_n));
  task automatic note(input logic ok, input string msg);
    num_checks++;
    if (ok !== 1'b1)
    begin
      fails++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge pclk)
  begin
    if (qual !== last_qual)
    begin
      note(exp_q.size() != 0 && qual === exp_q[0], "unexpected qualified pin change");
      note(conv_q === qual[0], "conversion start differs from pin 0");
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
      last_qual = qual;
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (pready !== 1'b1)
    begin
      note(1'b0, "bus answer timed out");
      tally_and_finish;
    end
    if (!wr)
      note({pslverr, prdata} === e, "read data mismatch");
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic qual_case(input logic [15:0] sel, input logic [15:0] per, input int w, input logic [15:0] acc);
    logic [15:0] v;
    v = 16'($random(seed)) | 16'h1111;
    apb(1'b1, ADDR_QUAL_SELECT, {16'h0000, sel}, NO_DATA);
    apb(1'b1, ADDR_GROUP_CTRL, {16'h0000, per}, NO_DATA);
    apb(1'b0, ADDR_GROUP_CTRL, 32'h0000_0000, {17'h0_0000, per});
    if (acc == 16'hFFFF && per[7:0] != 8'h00)
      exp_q = {v & 16'hFF00, v, v & 16'h00FF, 16'h0000};
    else if (acc != 16'h0000)
      exp_q = {v & acc, 16'h0000};
    src.drive_pins(v, w);
    repeat (60) @(posedge pclk);
    note(exp_q.size() == 0, "qualified pins missed a change");
  endtask
  task automatic lp_case(input logic [31:0] lpc, input int s, input int pre, input int hold, input int lim,
    input logic [7:0] st);
    int n;
    n = 0;
    apb(1'b1, ADDR_LP_CTRL0, lpc, NO_DATA);
    apb(1'b1, ADDR_LP_CMD, 32'h0000_0001, NO_DATA);
    repeat (12) @(posedge pclk);
    note(clk_stop === lpc[LP_MODE_BIT], "clock stop level wrong");
    if (s == 3)
      repeat ((pre > 0) ? 2 : 1) exp_q = {exp_q, 16'h0001, 16'h0000};
    if (pre > 0)
    begin
      src.raise(s, pre);
      repeat (40) @(posedge pclk);
      note(lp_active === 1'b1, "short wake pulse accepted");
    end
    fork
      src.raise(s, hold);
      while (cpu_resume !== 1'b1 && n < 1200)
      begin
        @(posedge pclk);
        n++;
      end
    join
    note(n <= lim + 2, "wake latency too long");
    if (n >= 1200)
      tally_and_finish;
    repeat (20) @(posedge pclk);
    apb(1'b0, ADDR_LP_STATUS, 32'h0000_0000, {25'h000_0000, st});
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 4; i++)
      apb(1'b0, 8'(4 * i), 32'h0000_0000, NO_DATA);
    apb(1'b0, 8'h1C, 32'h0000_0000, 33'h1_0000_0000);
    apb(1'b1, ADDR_LP_CTRL0, 32'h0000_013F, NO_DATA);
    apb(1'b0, ADDR_LP_CTRL0, 32'h0000_0000, 33'h0_0000_013F);
    qual_case(16'h0000, 16'h0000, 2, 16'h0000);
    qual_case(16'h0F0F, 16'h0000, 3, 16'hF0F0);
    qual_case(16'hFFFF, 16'h0000, 5, 16'h0000);
    qual_case(16'hFFFF, 16'h0000, 6, 16'hFFFF);
    qual_case(16'h0000, 16'h0002, 6, 16'hFF00);
    qual_case(16'h0000, 16'h0002, 14, 16'hFFFF);
    qual_case(16'h0000, 16'h00FF, 100, 16'hFF00);
    apb(1'b1, ADDR_GROUP_CTRL, 32'h0000_0000, NO_DATA);
    apb(1'b1, ADDR_WAKE_EN, 32'h0000_0001, NO_DATA);
    lp_case(32'h0000_0000, 0, 0, 3, 20, 8'h20);
    lp_case(32'h0000_0000, 1, 0, 3, 20, 8'h40);
    lp_case(32'h0000_0000, 2, 0, 3, 20, 8'h80);
    lp_case(32'h0000_0000, 3, 0, 8, 22, 8'h10);
    flash_sleep <= 1'b1;
    lp_case(32'h0000_0000, 0, 0, 3, 1050, 8'h20);
    flash_sleep <= 1'b0;
    lp_case(32'h0000_0105, 3, 4, 16, 116, 8'h10);
    tally_and_finish;
  end
endmodule
bind iqw_top iqw_top_monitor #(.NUM_GROUPS(NUM_GROUPS)) mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .gpio_pin_in(gpio_pin_in), .qual_pin_out(qual_pin_out),
  .ext_int_conv_start_in(ext_int_conv_start_in), .ext_int_conv_start_q(ext_int_conv_start_q),
  .watchdog_wake_irq(watchdog_wake_irq), .ext_nonmaskable_irq(ext_nonmaskable_irq),
  .ext_reset_pin_n(ext_reset_pin_n), .flash_sleep(flash_sleep), .cpu_resume(cpu_resume),
  .lowpower_active(lowpower_active), .periph_clk_stop(periph_clk_stop));
